// >>> pkg/gcd_pkg.sv
package gcd_pkg;

  // ****************************************
  // Packet and command framing
  // ****************************************
  localparam logic [15:0] GCD_UDP_PORT = 16'h2710;
  localparam logic [7:0] GCD_ID_SELF = 8'hff;
  localparam logic [7:0] GCD_ID_PORT_MAX = 8'h0f;
  localparam logic [7:0] GCD_LEN_MIN = 8'h02;
  localparam logic [7:0] GCD_LEN_MAX = 8'hfe;
  localparam int GCD_HDR_BYTES = 2;

  // ****************************************
  // Queue sizing
  // ****************************************
  localparam int GCD_SLOTS = 15;
  localparam int GCD_PKT_BYTES = 256;

  // ****************************************
  // Timing
  // ****************************************
  localparam int GCD_CLK_NS = 10;
  localparam int GCD_RSP_TIMEOUT_NS = 10000000;
  // Longest wait rounds down
  localparam int GCD_RSP_TIMEOUT_CYC = GCD_RSP_TIMEOUT_NS / GCD_CLK_NS;

  // ****************************************
  // Dispatch states, Gray from GCD_IDLE through the command loop
  // ****************************************
  typedef enum logic [3:0] {
    GCD_IDLE = 4'h0,
    GCD_FETCH_ID = 4'h1,
    GCD_FETCH_LEN = 4'h3,
    GCD_CONNECT = 4'h2,
    GCD_SEND = 4'h6,
    GCD_WAIT = 4'h7,
    GCD_DISCONNECT = 4'h5,
    GCD_FINISH = 4'h4,
    GCD_DRAIN = 4'hc
  } gcd_state_t;

endpackage

// >>> core/gcd_packet_pool.sv
`timescale 1ns/1ps

module gcd_packet_pool import gcd_pkg::*; #(
  parameter int SLOTS = GCD_SLOTS,
  parameter int BYTES = GCD_PKT_BYTES,
  localparam int SW = $clog2(SLOTS + 1),
  localparam int IW = $clog2(BYTES) + 1
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  input wire logic in_last,
  input wire logic [15:0] in_dst_port,
  input wire logic [15:0] in_src_port,
  input wire logic [31:0] in_src_addr,
  input wire logic [IW-1:0] rd_idx,
  input wire logic release_slot,
  output logic head_avail,
  output logic [IW-1:0] head_len,
  output logic [47:0] head_tag,
  output logic [7:0] rd_data,
  output logic drop
);

  typedef struct packed {
    logic [SW-1:0] wr_slot;
    logic [SW-1:0] rd_slot;
    logic [SW-1:0] count;
    logic [IW-1:0] wr_idx;
    logic in_pkt;
    logic dropping;
    logic drop;
  } gcd_pool_t;

  gcd_pool_t q, d;
  logic [7:0] mem [SLOTS][BYTES];
  logic [IW-1:0] len_mem [SLOTS];
  logic [47:0] tag_mem [SLOTS];
  logic keep, wr_en, commit;
  logic [IW-1:0] idx;

  initial begin
    if (SLOTS < 1 || BYTES < 4 || (BYTES & (BYTES - 1)) != 0) begin
      $error("gcd_packet_pool: bad SLOTS or BYTES");
    end
  end

  function automatic logic [SW-1:0] slot_next(input logic [SW-1:0] s);
    return (s == SW'(SLOTS - 1)) ? '0 : SW'(s + 1'b1);
  endfunction

  // ****************************************
  // Slot ring: oldest packet at rd_slot
  // ****************************************
  always_comb begin
    d = q;
    d.drop = 1'b0;
    idx = q.in_pkt ? q.wr_idx : '0;
    // Full pool or wrong port drops the whole packet
    keep = q.in_pkt ? !q.dropping :
      (q.count != SW'(SLOTS) && in_dst_port == GCD_UDP_PORT);
    wr_en = keep && (idx < IW'(BYTES));
    commit = in_valid && in_last && wr_en;
    if (in_valid) begin
      if (in_last) begin
        d.in_pkt = 1'b0;
        d.drop = !wr_en;
      end else begin
        d.in_pkt = 1'b1;
        d.dropping = !wr_en;
        d.wr_idx = IW'(idx + 1'b1);
      end
    end
    // Queue while busy, from any client
    if (commit) begin
      d.wr_slot = slot_next(q.wr_slot);
    end
    // Oldest first
    if (release_slot) begin
      d.rd_slot = slot_next(q.rd_slot);
    end
    if (commit && !release_slot) begin
      d.count = SW'(q.count + 1'b1);
    end else if (!commit && release_slot) begin
      d.count = SW'(q.count - 1'b1);
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Storage carries no reset; only committed slots are ever read
  always_ff @(posedge mclk) begin
    if (in_valid && wr_en) begin
      mem[q.wr_slot][idx[IW-2:0]] <= in_data;
    end
    if (commit) begin
      len_mem[q.wr_slot] <= IW'(idx + 1'b1);
      tag_mem[q.wr_slot] <= {in_src_addr, in_src_port};
    end
  end

  assign head_avail = (q.count != '0);
  assign head_len = len_mem[q.rd_slot];
  assign head_tag = tag_mem[q.rd_slot];
  assign rd_data = mem[q.rd_slot][rd_idx[IW-2:0]];
  assign drop = q.drop;

endmodule // gcd_packet_pool

// >>> core/gcd_dispatcher.sv
`timescale 1ns/1ps

// Operation
// - One shared link serves all sixteen module ports, one at a time
// - Each packet starts one sequence: extract, send, await reply, append
// - After the last command, send the response and end the sequence
// - Connect the link to the target port before, disconnect after
// - Queue new packets during a sequence while a buffer is free
// - After each response, serve the oldest queued packet first
// - Packets from other clients are queued like any other
// - Operations sit back to back and run strictly in order
// - A bad operation stops the list and yields no reply
// - Each operation is one opcode byte plus operation-specific parameters
// - Command header is target identifier then byte count, list follows
// - Target identifier is 0 to 15, or all ones for the dispatcher
// - Byte count includes the header and lies in 2 to 254
// - Module operation lists pass through uninterpreted
// - Commands go to UDP port 10000; responses come from it
// - A module given an erroneous command sends no reply
module gcd_dispatcher import gcd_pkg::*; #(
  parameter int SLOTS = GCD_SLOTS,
  parameter int PKT_BYTES = GCD_PKT_BYTES,
  parameter int RSP_TIMEOUT_CYC = GCD_RSP_TIMEOUT_CYC,
  localparam int IW = $clog2(PKT_BYTES) + 1
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic pkt_valid,
  input wire logic [7:0] pkt_data,
  input wire logic pkt_last,
  input wire logic [15:0] pkt_dst_port,
  input wire logic [15:0] pkt_src_port,
  input wire logic [31:0] pkt_src_addr,
  input wire logic link_tx_ready,
  input wire logic link_rx_valid,
  input wire logic [7:0] link_rx_data,
  input wire logic link_rx_last,
  output logic [3:0] link_sel,
  output logic link_connect,
  output logic link_tx_valid,
  output logic [7:0] link_tx_data,
  output logic link_tx_last,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_end,
  output logic [15:0] rsp_src_port,
  output logic [15:0] rsp_dst_port,
  output logic [31:0] rsp_dst_addr,
  output logic busy,
  output logic pkt_drop
);

  typedef struct packed {
    gcd_state_t st;
    logic [IW-1:0] rd_idx;
    logic [IW-1:0] cmd_end;
    logic [31:0] timer;
    logic [3:0] sel;
    logic connect;
    logic tx_valid;
    logic [7:0] tx_data;
    logic tx_last;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic rsp_end;
    logic [15:0] rsp_src_port;
    logic [15:0] rsp_dst_port;
    logic [31:0] rsp_dst_addr;
    logic busy;
    logic release_slot;
  } gcd_disp_t;

  gcd_disp_t q, d;
  logic head_avail;
  logic [IW-1:0] head_len;
  logic [47:0] head_tag;
  logic [7:0] rd_data;
  logic [IW-1:0] end_calc;
  logic cmd_ok;

  initial begin
    if (RSP_TIMEOUT_CYC < 1 || PKT_BYTES < 4) begin
      $error("gcd_dispatcher: bad parameters");
    end
  end

  // Identifier legal for a module port or the dispatcher itself
  function automatic logic id_legal(input logic [7:0] id);
    return (id <= GCD_ID_PORT_MAX) || (id == GCD_ID_SELF);
  endfunction

  gcd_packet_pool #(
    .SLOTS(SLOTS),
    .BYTES(PKT_BYTES)
  ) u_pool (
    .mclk(mclk),
    .reset(reset),
    .in_valid(pkt_valid),
    .in_data(pkt_data),
    .in_last(pkt_last),
    .in_dst_port(pkt_dst_port),
    .in_src_port(pkt_src_port),
    .in_src_addr(pkt_src_addr),
    .rd_idx(q.rd_idx),
    .release_slot(q.release_slot),
    .head_avail(head_avail),
    .head_len(head_len),
    .head_tag(head_tag),
    .rd_data(rd_data),
    .drop(pkt_drop)
  );

  // ****************************************
  // Dispatch sequence
  // ****************************************
  always_comb begin
    d = q;
    d.rsp_valid = 1'b0;
    d.rsp_end = 1'b0;
    d.release_slot = 1'b0;
    // Count covers both header bytes, so command ends at start + count
    end_calc = IW'(q.rd_idx - 1'b1) + IW'(rd_data);
    cmd_ok = id_legal(q.tx_data) && rd_data >= GCD_LEN_MIN &&
      rd_data <= GCD_LEN_MAX && end_calc <= head_len;
    case (q.st)
      GCD_IDLE: begin
        if (head_avail) begin
          d.rsp_dst_port = head_tag[15:0];
          d.rsp_dst_addr = head_tag[47:16];
          d.rd_idx = '0;
          d.busy = 1'b1;
          d.st = GCD_FETCH_ID;
        end
      end
      GCD_FETCH_ID: begin
        // Commands packed without gaps; a lone trailing byte ends it
        if (IW'(q.rd_idx + 1'b1) >= head_len) begin
          d.st = GCD_FINISH;
        end else begin
          d.tx_data = rd_data; // Identifier parked until validated
          d.rd_idx = IW'(q.rd_idx + 1'b1);
          d.st = GCD_FETCH_LEN;
        end
      end
      GCD_FETCH_LEN: begin
        d.cmd_end = end_calc;
        d.rd_idx = IW'(q.rd_idx + 1'b1);
        if (!cmd_ok) begin
          // Framing is lost, so nothing after this can be trusted
          d.st = GCD_FINISH;
        end else if (q.tx_data == GCD_ID_SELF) begin
          // Local utility commands are not served here; skip it
          d.rd_idx = end_calc;
          d.st = GCD_FETCH_ID;
        end else begin
          d.sel = q.tx_data[3:0];
          d.connect = 1'b1;
          d.st = GCD_CONNECT;
        end
      end
      GCD_CONNECT: begin
        // One cycle for the port mux to settle before data moves
        d.st = GCD_SEND;
      end
      GCD_SEND: begin
        if (!q.tx_valid || link_tx_ready) begin
          if (q.rd_idx < q.cmd_end) begin
            d.tx_valid = 1'b1;
            d.tx_data = rd_data; // Opaque
            d.tx_last = (IW'(q.rd_idx + 1'b1) == q.cmd_end);
            d.rd_idx = IW'(q.rd_idx + 1'b1);
          end else begin
            d.tx_valid = 1'b0;
            d.tx_last = 1'b0;
            d.timer = '0;
            d.st = GCD_WAIT;
          end
        end
      end
      GCD_WAIT: begin
        d.timer = q.timer + 1'b1;
        if (link_rx_valid) begin
          d.rsp_valid = 1'b1; // Reply appended as it arrives
          d.rsp_data = link_rx_data;
        end
        if (link_rx_valid && link_rx_last) begin
          d.st = GCD_DISCONNECT;
        end else if (q.timer >= 32'(RSP_TIMEOUT_CYC - 1)) begin
          // Silent module must not stall
          d.st = GCD_DISCONNECT;
        end
      end
      GCD_DISCONNECT: begin
        d.connect = 1'b0;
        d.st = GCD_FETCH_ID;
      end
      GCD_FINISH: begin
        d.rsp_end = 1'b1;
        d.release_slot = 1'b1;
        d.st = GCD_DRAIN;
      end
      GCD_DRAIN: begin
        // Lets the pool retire the slot before the next head is read
        d.busy = 1'b0;
        d.st = GCD_IDLE;
      end
      default: begin
        d.st = GCD_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      q <= '0;
      q.st <= GCD_IDLE;
      q.rsp_src_port <= GCD_UDP_PORT;
    end else begin
      q <= d;
    end
  end

  assign link_sel = q.sel;
  assign link_connect = q.connect;
  assign link_tx_valid = q.tx_valid;
  assign link_tx_data = q.tx_data;
  assign link_tx_last = q.tx_last;
  assign rsp_valid = q.rsp_valid;
  assign rsp_data = q.rsp_data;
  assign rsp_end = q.rsp_end;
  assign rsp_src_port = q.rsp_src_port;
  assign rsp_dst_port = q.rsp_dst_port;
  assign rsp_dst_addr = q.rsp_dst_addr;
  assign busy = q.busy;

endmodule // gcd_dispatcher

// >>> bench/gcd_dispatcher_monitor.sv
`timescale 1ns/1ps

module gcd_dispatcher_monitor import gcd_pkg::*; #(
  parameter int RSP_TIMEOUT_CYC = GCD_RSP_TIMEOUT_CYC
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic pkt_valid,
  input wire logic pkt_last,
  input wire logic link_tx_ready,
  input wire logic link_rx_valid,
  input wire logic [7:0] link_rx_data,
  input wire logic link_rx_last,
  input wire logic [3:0] link_sel,
  input wire logic link_connect,
  input wire logic link_tx_valid,
  input wire logic [7:0] link_tx_data,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_end,
  input wire logic [15:0] rsp_src_port,
  input wire logic busy,
  input wire logic pkt_drop
);
  // ****************************************
  // Link and response checks
  // ****************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // Slack covers a full command sent at half rate
  int hold_q;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      hold_q <= 0;
    end else begin
      hold_q <= link_connect ? hold_q + 1 : 0;
    end
  end
  a_src_port_fixed: assert property (
    rsp_src_port == GCD_UDP_PORT) else $error("bad source port");
  a_tx_connected: assert property (
    link_tx_valid |-> link_connect) else $error("send while detached");
  a_one_port: assert property (
    link_connect && $past(link_connect) |-> $stable(link_sel))
    else $error("port changed while attached");
  a_tx_held: assert property (
    link_tx_valid && !link_tx_ready |=> link_tx_valid && $stable(link_tx_data))
    else $error("command byte not held");
  a_reply_copied: assert property (
    link_rx_valid |=> rsp_valid && rsp_data == $past(link_rx_data))
    else $error("reply byte not copied");
  a_detach_after: assert property (
    link_rx_valid && link_rx_last |-> ##[1:3] !link_connect)
    else $error("link not released");
  a_drop_cause: assert property (
    pkt_drop |-> $past(pkt_valid) && $past(pkt_last))
    else $error("drop without packet end");
  a_end_link_free: assert property (
    rsp_end |-> !link_connect && busy) else $error("end while attached");
  a_reply_bound: assert property (
    hold_q < RSP_TIMEOUT_CYC + 600) else $error("reply wait too long");
endmodule // gcd_dispatcher_monitor

bind gcd_dispatcher gcd_dispatcher_monitor #(
  .RSP_TIMEOUT_CYC(RSP_TIMEOUT_CYC)
) u_mon (
  .mclk(mclk),
  .reset(reset),
  .pkt_valid(pkt_valid),
  .pkt_last(pkt_last),
  .link_tx_ready(link_tx_ready),
  .link_rx_valid(link_rx_valid),
  .link_rx_data(link_rx_data),
  .link_rx_last(link_rx_last),
  .link_sel(link_sel),
  .link_connect(link_connect),
  .link_tx_valid(link_tx_valid),
  .link_tx_data(link_tx_data),
  .rsp_valid(rsp_valid),
  .rsp_data(rsp_data),
  .rsp_end(rsp_end),
  .rsp_src_port(rsp_src_port),
  .busy(busy),
  .pkt_drop(pkt_drop)
);

// >>> bench/gcd_module_model.sv
`timescale 1ns/1ps

module gcd_module_model (
  input wire logic mclk,
  input wire logic [3:0] link_sel,
  input wire logic link_connect,
  input wire logic link_tx_valid,
  input wire logic [7:0] link_tx_data,
  input wire logic link_tx_last,
  output logic link_tx_ready = 1'b0,
  output logic link_rx_valid = 1'b0,
  output logic [7:0] link_rx_data = 8'h00,
  output logic link_rx_last = 1'b0
);
  // ****************************************
  // Attached module
  // ****************************************
  logic [7:0] seen_q [$];
  int ph = 0;
  int nrx = 0;
  logic bad = 1'b0;
  always @(posedge mclk) begin
    link_rx_valid <= 1'b0;
    link_rx_last <= 1'b0;
    // Idle reply line flips so a stale byte cannot pass
    link_rx_data <= ~link_rx_data;
    // Half rate ready: prompt and stalled cycles alike
    link_tx_ready <= ~link_tx_ready;
    if (link_connect && link_tx_valid && link_tx_ready) begin
      seen_q.push_back(link_tx_data);
      nrx <= nrx + 1;
      bad <= bad | (link_tx_data == 8'h00);
      ph <= link_tx_last ? 1 : 0;
    end
    if (ph == 1 && bad) begin
      ph <= 0;
      nrx <= 0;
      bad <= 1'b0;
    end else if (ph == 1) begin
      link_rx_valid <= 1'b1;
      link_rx_data <= {4'h5, link_sel};
      ph <= 2;
    end else if (ph == 2) begin
      link_rx_valid <= 1'b1;
      link_rx_last <= 1'b1;
      link_rx_data <= nrx[7:0];
      ph <= 0;
      nrx <= 0;
    end
  end
endmodule // gcd_module_model

// >>> bench/gcd_dispatcher_test.sv
`timescale 1ns/1ps

module gcd_dispatcher_test;
  import gcd_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic pkt_valid = 1'b0;
  logic pkt_last = 1'b0;
  logic [7:0] pkt_data = 8'h00;
  logic [15:0] pkt_dst_port = 16'h0000;
  logic [15:0] pkt_src_port = 16'h0000;
  logic [31:0] pkt_src_addr = 32'h0a000007;
  logic link_tx_ready, link_rx_valid, link_rx_last, link_connect;
  logic link_tx_valid, link_tx_last, rsp_valid, rsp_end, busy, pkt_drop;
  logic [7:0] link_rx_data, link_tx_data, rsp_data;
  logic [3:0] link_sel;
  logic [15:0] rsp_src_port, rsp_dst_port;
  logic [31:0] rsp_dst_addr;
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int drops = 0;
  logic [7:0] rsp_q [$];
  logic [15:0] end_q [$];

  gcd_dispatcher #(
    .RSP_TIMEOUT_CYC(80)
  ) dut (
    .mclk(mclk),
    .reset(reset),
    .pkt_valid(pkt_valid),
    .pkt_data(pkt_data),
    .pkt_last(pkt_last),
    .pkt_dst_port(pkt_dst_port),
    .pkt_src_port(pkt_src_port),
    .pkt_src_addr(pkt_src_addr),
    .link_tx_ready(link_tx_ready),
    .link_rx_valid(link_rx_valid),
    .link_rx_data(link_rx_data),
    .link_rx_last(link_rx_last),
    .link_sel(link_sel),
    .link_connect(link_connect),
    .link_tx_valid(link_tx_valid),
    .link_tx_data(link_tx_data),
    .link_tx_last(link_tx_last),
    .rsp_valid(rsp_valid),
    .rsp_data(rsp_data),
    .rsp_end(rsp_end),
    .rsp_src_port(rsp_src_port),
    .rsp_dst_port(rsp_dst_port),
    .rsp_dst_addr(rsp_dst_addr),
    .busy(busy),
    .pkt_drop(pkt_drop)
  );
  gcd_module_model model (
    .mclk(mclk),
    .link_sel(link_sel),
    .link_connect(link_connect),
    .link_tx_valid(link_tx_valid),
    .link_tx_data(link_tx_data),
    .link_tx_last(link_tx_last),
    .link_tx_ready(link_tx_ready),
    .link_rx_valid(link_rx_valid),
    .link_rx_data(link_rx_data),
    .link_rx_last(link_rx_last)
  );

  initial forever #5 mclk = ~mclk;

  always @(posedge mclk) begin
    cycles++;
    if (rsp_valid === 1'b1) rsp_q.push_back(rsp_data);
    if (rsp_end === 1'b1) end_q.push_back(rsp_dst_port);
    if (pkt_drop === 1'b1) drops++;
    if (cycles == 20000) begin
      n_errors++;
      results();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cmp_q(input logic [7:0] got [$], input logic [7:0] exp [$]);
    check(got.size(), exp.size());
    foreach (exp[i]) if (i < got.size()) check(got[i], exp[i]);
  endtask

  task automatic send(input logic [7:0] b [$], input logic [15:0] src,
                      input logic [15:0] dst);
    foreach (b[i]) begin
      @(negedge mclk);
      pkt_valid = 1'b1;
      pkt_data = b[i];
      pkt_last = (i == b.size() - 1);
      pkt_dst_port = dst;
      pkt_src_port = src;
    end
  endtask

  task automatic settle(input int n);
    @(negedge mclk);
    pkt_valid = 1'b0;
    pkt_last = 1'b0;
    while (end_q.size() < n) @(posedge mclk);
  endtask

  task automatic t_single();
    check(rsp_src_port, 16'h2710);
    send('{8'h03, 8'h03, 8'haa, 8'hff, 8'h03, 8'h77,
           8'h05, 8'h04, 8'h11, 8'h22, 8'h09}, 16'h1b59, GCD_UDP_PORT);
    settle(1);
    check(end_q[0], 16'h1b59);
    check(rsp_dst_addr, pkt_src_addr);
    @(negedge mclk);
    check(busy, 1'b0);
    cmp_q(rsp_q, '{8'h53, 8'h01, 8'h55, 8'h02});
    cmp_q(model.seen_q, '{8'haa, 8'h11, 8'h22});
    $display("test single done");
  endtask

  task automatic t_fifo();
    for (int k = 1; k < 4; k++) begin
      send('{8'(k), 8'h03, 8'(8'h40 + k)}, 16'(16'h1000 + k), GCD_UDP_PORT);
    end
    settle(3);
    check(end_q.size(), 3);
    cmp_q(rsp_q, '{8'h51, 8'h01, 8'h52, 8'h01, 8'h53, 8'h01});
    foreach (end_q[i]) check(end_q[i], 16'(16'h1001 + i));
    $display("test queue order done");
  endtask

  task automatic t_bad_header();
    logic [7:0] bid [3] = '{8'h20, 8'h04, 8'h04};
    logic [7:0] bcn [3] = '{8'h03, 8'h01, 8'hff};
    for (int k = 0; k < 3; k++) begin
      rsp_q.delete();
      end_q.delete();
      model.seen_q.delete();
      send('{8'h03, 8'h03, 8'haa, bid[k], bcn[k], 8'hbb,
             8'h06, 8'h03, 8'hcc}, 16'h2000, GCD_UDP_PORT);
      settle(1);
      cmp_q(rsp_q, '{8'h53, 8'h01});
      cmp_q(model.seen_q, '{8'haa});
    end
    send('{8'h03, 8'h03, 8'haa}, 16'h2001, 16'h2711);
    settle(1);
    repeat (20) @(posedge mclk);
    check(drops, 1);
    check(end_q.size(), 1);
    $display("test bad header done");
  endtask

  task automatic t_full();
    drops = 0;
    for (int k = 0; k < 17; k++) begin
      send('{8'h01, 8'h03, 8'h00, 8'h02, 8'h03, 8'h00,
             8'h03, 8'h03, 8'h00}, 16'(16'h3000 + k), GCD_UDP_PORT);
    end
    settle(15);
    check(drops, 2);
    check(rsp_q.size(), 0);
    check(end_q[14], 16'h300e);
    $display("test full pool done");
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    reset = 1'b0;
    t_single();
    rsp_q.delete();
    end_q.delete();
    t_fifo();
    t_bad_header();
    end_q.delete();
    rsp_q.delete();
    t_full();
    results();
  end
endmodule // gcd_dispatcher_test
